/* File: hw/wrs_consts.vh */
// shared constants of the weighing result send control block
`ifndef WRS_CONSTS_VH
`define WRS_CONSTS_VH
// register byte offsets
`define WRS_OFS_CMD      5'h00
`define WRS_OFS_PARAM    5'h04
`define WRS_OFS_CONFIG   5'h08
`define WRS_OFS_STATUS   5'h0c
`define WRS_OFS_UNIT     5'h10
// command word fields
`define WRS_CMD_OP       3:0
`define WRS_CMD_HASP     4
`define WRS_CMD_DEC      7:5
`define WRS_CMD_HASDEC   8
`define WRS_CMD_UFORM    9
`define WRS_CMD_UNIT     15:12
// opcodes
`define WRS_OP_SI        4'h1
`define WRS_OP_SIR       4'h2
`define WRS_OP_S         4'h3
`define WRS_OP_SNR       4'h4
`define WRS_OP_SR        4'h5
`define WRS_OP_T         4'h6
`define WRS_OP_U         4'h7
// config fields and reset value
`define WRS_CFG_ASD      2:0
`define WRS_CFG_TXALL    3
`define WRS_CFG_RST      4'h4
// result kinds
`define WRS_K_STABLE     3'h0
`define WRS_K_UNSTABLE   3'h1
`define WRS_K_INVALID    3'h2
`define WRS_K_OVER       3'h3
`define WRS_K_UNDER      3'h4
`define WRS_K_ERROR      3'h5
`define WRS_K_TDONE      3'h6
// send modes
`define WRS_M_IDLE       3'h0
`define WRS_M_IMM        3'h1
`define WRS_M_CONT       3'h2
`define WRS_M_STB1       3'h3
`define WRS_M_NEXT       3'h4
`define WRS_M_SREP       3'h5
// phases of the stable modes
`define WRS_P_WSTB       2'h0
`define WRS_P_WCHG       2'h1
`define WRS_P_WCLR       2'h2
// weights in milligram steps
`define WRS_MIN_STEP     24'h00000a
`define WRS_MIN_DIV      24'h000064
`define WRS_DEC_MAX      3'h7
`define WRS_AUTO_SHIFT   3
// timing: clock in Hz, repeat period in ms (2.5 per second), tare limit in s
`define WRS_CLK_HZ       40'hbebc200
`define WRS_REP_MS       40'h190
`define WRS_TARE_S       40'h3c
`define WRS_MS_PER_S     40'h3e8
`endif

/* File: hw/wrs_timer.v */
// free counting timer giving a done pulse every LIMIT cycles of run
`timescale 1ns/1ps
module wrs_timer #(
  parameter [39:0] LIMIT = 40'h10
) (
  // clock and reset
  input  wire i_clk,
  input  wire i_rst_n,
  // control
  input  wire i_run,
  output wire o_done
);
  reg  [39:0] cnt_ff;
  wire        last = (cnt_ff == LIMIT - 40'h1);

  assign o_done = i_run & last;

  always @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_ff <= 40'h0;
    else if (!i_run || last)
      cnt_ff <= 40'h0;
    else
      cnt_ff <= cnt_ff + 40'h1;
  end
endmodule // wrs_timer

/* File: hw/wrs_classify.v */
// classifies the current reading into a result kind
`timescale 1ns/1ps
`include "wrs_consts.vh"
module wrs_classify (
  // reading state
  input  wire       i_valid,
  input  wire       i_stable,
  input  wire       i_over,
  input  wire       i_under,
  input  wire       i_tare_busy,
  // kind
  output reg  [2:0] o_kind
);
  always @*
  begin
    if (i_over)
      o_kind = `WRS_K_OVER;
    else if (i_under)
      o_kind = `WRS_K_UNDER;
    else if (!i_valid || i_tare_busy)
      o_kind = `WRS_K_INVALID;
    else if (i_stable)
      o_kind = `WRS_K_STABLE;
    else
      o_kind = `WRS_K_UNSTABLE;
  end
endmodule // wrs_classify

/* File: hw/wrs_send_ctrl.v */
// weighing result send control with avalon register slave
//
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "wrs_consts.vh"
// Overview of operation
// - immediate send emits next result regardless
// - result kind marks stable or unstable
// - no valid reading sends invalid result
// - overload and underload get own codes
// - new send command cancels previous one
// - immediate send equals print key send-all
// - continuous results about 2.5 per second
// - continuous mode ended by any send
// - next stable, then per 10 mg change
// - change sends unstable then next stable
// - threshold default 12.5 percent, min 10 mg; code floors only the default, a given 1..9 mg threshold is accepted
// - threshold zero switches change mode off
// - bad threshold or detector off errors
// - tare waits stable, results invalid meanwhile
// - remote tare gives no tare-done message
// - tare timeout or overload sends error
// - after power fail only tare accepted
// - unit select overrides unit two
// - unit without parameter restores unit one
// - divisor form takes 0..7 decimals
// - too small divisor rejected with error
// - unit command resets running application
module wrs_send_ctrl #(
  parameter [39:0] REP_CYCLES  = `WRS_REP_MS * `WRS_CLK_HZ / `WRS_MS_PER_S,
  parameter [39:0] TARE_CYCLES = `WRS_TARE_S * `WRS_CLK_HZ
) (
  // clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rst_n,
  // avalon-mm slave
  input  wire [4:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // weighing core
  input  wire [23:0] i_wgt_value,
  input  wire        i_wgt_valid,
  input  wire        i_wgt_stable,
  input  wire        i_wgt_over,
  input  wire        i_wgt_under,
  input  wire        i_app_active,
  input  wire        i_print_key,
  input  wire        i_tare_key,
  input  wire        i_power_fail,
  // result stream
  output wire        o_res_valid,
  output wire [2:0]  o_res_kind,
  output wire [23:0] o_res_value,
  input  wire        i_res_ready,
  // control outputs
  output wire        o_tare_req,
  output wire        o_app_reset,
  output wire        o_unit_override,
  output wire        o_unit_custom,
  output wire [3:0]  o_unit_code,
  output wire [2:0]  o_unit_dec,
  output wire [23:0] o_unit_div
);
  reg         rst_meta_ff;
  reg         rst_sync_ff;
  reg         ack_ff;
  reg         wait_ff;
  reg  [31:0] rdata_ff;
  reg  [31:0] rd_mux;
  reg  [23:0] param_ff;
  reg  [3:0]  cfg_ff;
  reg  [2:0]  mode_ff;
  reg  [1:0]  phase_ff;
  reg  [23:0] ref_ff;
  reg  [23:0] thr_ff;
  reg         thr_auto_ff;
  reg         cont_due_ff;
  reg         err_pend_ff;
  reg         tdone_pend_ff;
  reg         lock_ff;
  reg         tare_busy_ff;
  reg         tare_remote_ff;
  reg         tare_req_ff;
  reg         app_rst_ff;
  reg         res_valid_ff;
  reg  [2:0]  res_kind_ff;
  reg  [23:0] res_value_ff;
  reg         u_act_ff;
  reg         u_cust_ff;
  reg  [3:0]  u_code_ff;
  reg  [2:0]  u_dec_ff;
  reg  [23:0] u_div_ff;
  reg  [2:0]  nxt_mode;
  reg  [1:0]  nxt_phase;
  reg  [23:0] nxt_ref;
  reg  [23:0] nxt_thr;
  reg         nxt_thr_auto;
  reg         nxt_cont_due;
  reg         nxt_tare_busy;
  reg         nxt_tare_remote;
  reg         nxt_tare_req;
  reg         err_set;
  reg         tdone_set;
  reg         emit;
  reg  [2:0]  emit_kind;
  wire        rst_n = rst_sync_ff;
  wire [2:0]  cls_kind;
  wire        rep_tick;
  wire        tare_tmo;
  wire [31:0] bmask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                       {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire        wr_go = ack_ff & i_avs_write;
  wire        cmd_stb = wr_go & (i_avs_address == `WRS_OFS_CMD) & i_avs_byteenable[0];
  wire [3:0]  op = i_avs_writedata[`WRS_CMD_OP];
  wire        has_p = i_avs_writedata[`WRS_CMD_HASP];
  wire        t_ok = cmd_stb & (op == `WRS_OP_T);
  wire        cmd_ok = cmd_stb & (!lock_ff | (op == `WRS_OP_T));
  wire        asd_off = (cfg_ff[`WRS_CFG_ASD] == 3'h0);
  wire        key_si = i_print_key & !lock_ff & cfg_ff[`WRS_CFG_TXALL];
  wire        key_s = i_print_key & !lock_ff & !cfg_ff[`WRS_CFG_TXALL];
  wire        do_si = (cmd_ok & (op == `WRS_OP_SI)) | key_si;
  wire        do_s = (cmd_ok & (op == `WRS_OP_S)) | key_s;
  wire        do_u = cmd_ok & (op == `WRS_OP_U);
  wire        tare_go = t_ok | (i_tare_key & !lock_ff);
  wire        wgt_ok = i_wgt_valid & i_wgt_stable & !i_wgt_over & !i_wgt_under;
  wire        slot_free = !res_valid_ff | i_res_ready;
  wire        err_take = slot_free & err_pend_ff;
  wire        tdone_take = slot_free & !err_pend_ff & tdone_pend_ff;
  wire        can_emit = slot_free & !err_pend_ff & !tdone_pend_ff;
  wire        ovun = i_wgt_over | i_wgt_under;
  wire [24:0] dif = {i_wgt_value[23], i_wgt_value} - {ref_ff[23], ref_ff};
  wire [24:0] mag = dif[24] ? (25'h0 - dif) : dif;
  wire [23:0] ref_mag = ref_ff[23] ? (24'h0 - ref_ff) : ref_ff;
  wire [23:0] auto_thr = ref_mag >> `WRS_AUTO_SHIFT;
  wire [23:0] thr_eff = (thr_auto_ff && auto_thr < `WRS_MIN_STEP) ? `WRS_MIN_STEP
                      : (thr_auto_ff ? auto_thr : thr_ff);
  wire [23:0] step = (mode_ff == `WRS_M_SREP) ? thr_eff : `WRS_MIN_STEP;

  // reset release
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  wrs_classify u_cls (
    .i_valid     (i_wgt_valid),
    .i_stable    (i_wgt_stable),
    .i_over      (i_wgt_over),
    .i_under     (i_wgt_under),
    .i_tare_busy (tare_busy_ff),
    .o_kind      (cls_kind)
  );

  wrs_timer #(.LIMIT(REP_CYCLES)) u_rep (
    .i_clk   (i_sys_clk),
    .i_rst_n (rst_n),
    .i_run   (mode_ff == `WRS_M_CONT),
    .o_done  (rep_tick)
  );

  wrs_timer #(.LIMIT(TARE_CYCLES)) u_tare (
    .i_clk   (i_sys_clk),
    .i_rst_n (rst_n),
    .i_run   (tare_busy_ff & !tare_go),
    .o_done  (tare_tmo)
  );

  // register read mux
  always @*
  begin
    case (i_avs_address)
      `WRS_OFS_PARAM:  rd_mux = {8'h0, param_ff};
      `WRS_OFS_CONFIG: rd_mux = {28'h0, cfg_ff};
      `WRS_OFS_STATUS: rd_mux = {22'h0, err_pend_ff, lock_ff, tare_busy_ff, thr_auto_ff,
                                 res_valid_ff, phase_ff, mode_ff};
      `WRS_OFS_UNIT:   rd_mux = {23'h0, u_act_ff, u_cust_ff, u_dec_ff, u_code_ff};
      default:         rd_mux = 32'h0;
    endcase
  end

  // send engine and command decode
  always @*
  begin
    nxt_mode = mode_ff;
    nxt_phase = phase_ff;
    nxt_ref = ref_ff;
    nxt_thr = thr_ff;
    nxt_thr_auto = thr_auto_ff;
    nxt_cont_due = cont_due_ff | rep_tick;
    nxt_tare_busy = tare_busy_ff;
    nxt_tare_remote = tare_remote_ff;
    nxt_tare_req = 1'b0;
    err_set = 1'b0;
    tdone_set = 1'b0;
    emit = 1'b0;
    emit_kind = cls_kind;
    case (mode_ff)
      `WRS_M_IDLE: nxt_mode = `WRS_M_IDLE;
      `WRS_M_IMM:
        if (can_emit)
        begin
          emit = 1'b1;
          nxt_mode = `WRS_M_IDLE;
        end
      `WRS_M_CONT:
        if (can_emit && cont_due_ff)
        begin
          emit = 1'b1;
          nxt_cont_due = rep_tick;
        end
      `WRS_M_STB1, `WRS_M_NEXT, `WRS_M_SREP:
        case (phase_ff)
          `WRS_P_WSTB:
            if (can_emit && (ovun || cls_kind == `WRS_K_STABLE))
            begin
              emit = 1'b1;
              nxt_ref = i_wgt_value;
              nxt_phase = ovun ? `WRS_P_WCLR : `WRS_P_WCHG;
              if (mode_ff == `WRS_M_STB1)
                nxt_mode = `WRS_M_IDLE;
            end
          `WRS_P_WCHG:
            if (mag >= {1'b0, step})
            begin
              if (mode_ff != `WRS_M_SREP)
                nxt_phase = `WRS_P_WSTB;
              else if (can_emit)
              begin
                emit = 1'b1;
                emit_kind = `WRS_K_UNSTABLE;
                nxt_phase = `WRS_P_WSTB;
              end
            end
          `WRS_P_WCLR:
            if (!ovun)
              nxt_phase = `WRS_P_WSTB;
          default: nxt_phase = `WRS_P_WSTB;
        endcase
      default: nxt_mode = `WRS_M_IDLE;
    endcase
    // accepted send commands replace the active one
    if (do_si)
      nxt_mode = `WRS_M_IMM;
    else if (do_s)
    begin
      nxt_mode = `WRS_M_STB1;
      nxt_phase = `WRS_P_WSTB;
    end
    else if (cmd_ok && op == `WRS_OP_SIR)
    begin
      nxt_mode = `WRS_M_CONT;
      nxt_cont_due = 1'b1;
    end
    else if (cmd_ok && op == `WRS_OP_SNR)
    begin
      nxt_mode = `WRS_M_NEXT;
      nxt_phase = `WRS_P_WSTB;
    end
    else if (cmd_ok && op == `WRS_OP_SR)
    begin
      if (has_p && param_ff == 24'h0)
        nxt_mode = `WRS_M_IDLE;
      else if (asd_off || (has_p && (param_ff[23] || param_ff < 24'h1)))
        err_set = 1'b1;
      else
      begin
        nxt_mode = `WRS_M_SREP;
        nxt_phase = `WRS_P_WSTB;
        nxt_thr = param_ff;
        nxt_thr_auto = !has_p;
      end
    end
    else if (do_u && i_avs_writedata[`WRS_CMD_UFORM] &&
             (param_ff[23] || param_ff < `WRS_MIN_DIV))
      err_set = 1'b1;
    // taring
    if (tare_busy_ff)
    begin
      if (wgt_ok)
      begin
        nxt_tare_req = 1'b1;
        nxt_tare_busy = 1'b0;
        tdone_set = !tare_remote_ff;
      end
      else if (tare_tmo)
      begin
        nxt_tare_busy = 1'b0;
        err_set = 1'b1;
      end
    end
    if (tare_go)
    begin
      nxt_tare_remote = t_ok;
      if (ovun)
      begin
        nxt_tare_busy = 1'b0;
        err_set = 1'b1;
      end
      else if (wgt_ok || asd_off)
      begin
        nxt_tare_req = 1'b1;
        nxt_tare_busy = 1'b0;
        tdone_set = !t_ok;
      end
      else
        nxt_tare_busy = 1'b1;
    end
  end

  // bus slave, config and parameter registers
  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_ff <= 1'b0;
      wait_ff <= 1'b1;
      rdata_ff <= 32'h0;
      param_ff <= 24'h0;
      cfg_ff <= `WRS_CFG_RST;
    end
    else
    begin
      ack_ff <= (i_avs_read | i_avs_write) & !ack_ff;
      wait_ff <= !((i_avs_read | i_avs_write) & !ack_ff);
      if ((i_avs_read | i_avs_write) && !ack_ff)
        rdata_ff <= i_avs_read ? rd_mux : 32'h0;
      if (wr_go && i_avs_address == `WRS_OFS_PARAM)
        param_ff <= (param_ff & ~bmask[23:0]) | (i_avs_writedata[23:0] & bmask[23:0]);
      if (wr_go && i_avs_address == `WRS_OFS_CONFIG && i_avs_byteenable[0])
        cfg_ff <= i_avs_writedata[3:0];
    end
  end

  // engine, tare, lock and result registers
  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_ff <= `WRS_M_IDLE;
      phase_ff <= `WRS_P_WSTB;
      ref_ff <= 24'h0;
      thr_ff <= 24'h0;
      thr_auto_ff <= 1'b0;
      cont_due_ff <= 1'b0;
      err_pend_ff <= 1'b0;
      tdone_pend_ff <= 1'b0;
      lock_ff <= 1'b0;
      tare_busy_ff <= 1'b0;
      tare_remote_ff <= 1'b0;
      tare_req_ff <= 1'b0;
      res_valid_ff <= 1'b0;
      res_kind_ff <= `WRS_K_STABLE;
      res_value_ff <= 24'h0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      phase_ff <= nxt_phase;
      ref_ff <= nxt_ref;
      thr_ff <= nxt_thr;
      thr_auto_ff <= nxt_thr_auto;
      cont_due_ff <= nxt_cont_due;
      tare_busy_ff <= nxt_tare_busy;
      tare_remote_ff <= nxt_tare_remote;
      tare_req_ff <= nxt_tare_req;
      err_pend_ff <= (err_pend_ff & !err_take) | err_set;
      tdone_pend_ff <= (tdone_pend_ff & !tdone_take) | tdone_set;
      lock_ff <= i_power_fail | (lock_ff & !t_ok);
      if (err_take || tdone_take || emit)
      begin
        res_valid_ff <= 1'b1;
        res_kind_ff <= err_take ? `WRS_K_ERROR : (tdone_take ? `WRS_K_TDONE : emit_kind);
        res_value_ff <= (err_take || tdone_take) ? 24'h0 : i_wgt_value;
      end
      else if (i_res_ready)
        res_valid_ff <= 1'b0;
    end
  end

  // unit selection
  always @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      u_act_ff <= 1'b0;
      u_cust_ff <= 1'b0;
      u_code_ff <= 4'h0;
      u_dec_ff <= `WRS_DEC_MAX;
      u_div_ff <= 24'h0;
      app_rst_ff <= 1'b0;
    end
    else
    begin
      app_rst_ff <= do_u & i_app_active;
      if (do_u && !err_set)
      begin
        if (i_avs_writedata[`WRS_CMD_UFORM])
        begin
          u_act_ff <= 1'b1;
          u_cust_ff <= 1'b1;
          u_div_ff <= param_ff;
          u_dec_ff <= i_avs_writedata[`WRS_CMD_HASDEC] ? i_avs_writedata[`WRS_CMD_DEC]
                      : `WRS_DEC_MAX;
        end
        else
        begin
          u_act_ff <= has_p;
          u_cust_ff <= 1'b0;
          u_code_ff <= i_avs_writedata[`WRS_CMD_UNIT];
        end
      end
    end
  end

  assign o_avs_readdata = rdata_ff;
  assign o_avs_waitrequest = wait_ff;
  assign o_res_valid = res_valid_ff;
  assign o_res_kind = res_kind_ff;
  assign o_res_value = res_value_ff;
  assign o_tare_req = tare_req_ff;
  assign o_app_reset = app_rst_ff;
  assign o_unit_override = u_act_ff;
  assign o_unit_custom = u_cust_ff;
  assign o_unit_code = u_code_ff;
  assign o_unit_dec = u_dec_ff;
  assign o_unit_div = u_div_ff;
endmodule // wrs_send_ctrl

/* File: tb/wrs_send_ctrl_props.sv */
// port assertions of the result send control
`timescale 1ns/1ps
module wrs_props (
  // clock and reset
  input wire        i_sys_clk,
  input wire        i_rst_n,
  // register bus
  input wire [4:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire        o_avs_waitrequest,
  // core and stream
  input wire        i_wgt_over,
  input wire        i_app_active,
  input wire        i_power_fail,
  input wire        o_res_valid,
  input wire [2:0]  o_res_kind,
  input wire [23:0] o_res_value,
  input wire        i_res_ready,
  // control outputs
  input wire        o_tare_req,
  input wire        o_app_reset,
  input wire        o_unit_override,
  input wire        o_unit_custom
);
  logic lock_ff;
  wire  commit = i_avs_write && !o_avs_waitrequest && i_avs_address == 5'h00;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // commands other than tare are dropped while the lock stands
  always @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      lock_ff <= 1'h0;
    else if (i_power_fail)
      lock_ff <= 1'h1;
    else if (commit && i_avs_writedata[3:0] == 4'h6)
      lock_ff <= 1'h0;
  end
  sequence cmd_s(logic [3:0] op);
    commit && !lock_ff && i_avs_writedata[3:0] == op;
  endsequence
  a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest ##1 o_avs_waitrequest) else $error("bus answer not one cycle");
  a_idle_wait: assert property (!i_avs_read && !i_avs_write |=> o_avs_waitrequest)
    else $error("waitrequest low while idle");
  a_result_hold: assert property (o_res_valid && !i_res_ready
    |=> o_res_valid && $stable(o_res_kind) && $stable(o_res_value)) else $error("result changed while stalled");
  a_si_answer: assert property (cmd_s(4'h1) |-> ##[1:4] o_res_valid)
    else $error("no result after immediate send");
  a_tare_pulse: assert property (o_tare_req |=> !o_tare_req) else $error("tare pulse too long");
  a_tare_over: assert property (cmd_s(4'h6) ##0 (i_wgt_over && !o_res_valid)
    |-> ##[1:6] o_res_valid && o_res_kind == 3'h5) else $error("no error on tare in overload");
  a_unit_set: assert property (cmd_s(4'h7) ##0 (i_avs_writedata[4] && !i_avs_writedata[9])
    |-> ##[1:4] o_unit_override) else $error("unit not overridden");
  a_unit_clear: assert property (cmd_s(4'h7) ##0 !i_avs_writedata[4]
    |-> ##[1:4] !o_unit_override && !o_unit_custom) else $error("unit not cleared");
  a_app_reset: assert property (cmd_s(4'h7) ##0 i_app_active |-> ##[1:4] o_app_reset ##1 !o_app_reset)
    else $error("application not reset");
endmodule // wrs_props

/* File: tb/wrs_host_sink.sv */
// host side of the result stream, prompt or slow, with stall
`timescale 1ns/1ps
module wrs_host_sink (
  input  wire  i_clk,
  input  wire  i_stall,
  input  wire  i_slow,
  output logic o_ready
);
  logic [1:0] cnt_ff = 2'h0;
  initial o_ready = 1'h0;
  always @(posedge i_clk)
  begin
    cnt_ff  <= cnt_ff + 2'h1;
    o_ready <= !i_stall && (!i_slow || cnt_ff == 2'h3);
  end
endmodule // wrs_host_sink

/* File: tb/tb_wrs_send_ctrl.sv */
// self-checking bench of the weighing result send control
`timescale 1ns/1ps
module tb_wrs_send_ctrl;
  localparam [39:0] REP  = 40'h14;
  localparam [39:0] TARE = 40'h32;
  localparam logic [3:0] FL [5] = '{4'hc, 4'h8, 4'h0, 4'ha, 4'h9};
  logic        i_sys_clk = '0, i_rst_n = '0, i_avs_read = '0, i_avs_write = '0, i_print_key = '0;
  logic        i_wgt_valid = '0, i_wgt_stable = '0, i_wgt_over = '0, i_wgt_under = '0, i_tare_key = '0;
  logic        i_app_active = '0, i_power_fail = '0, stall = '0, slow = '0, strict = '1;
  logic [3:0]  i_avs_byteenable = 4'hf;
  logic [4:0]  i_avs_address = '0;
  logic [31:0] i_avs_writedata = '0, q, exp_q[$];
  logic [23:0] i_wgt_value = '0, w;
  wire  [31:0] o_avs_readdata;
  wire  [23:0] o_res_value, o_unit_div;
  wire  [3:0]  o_unit_code;
  wire  [2:0]  o_res_kind, o_unit_dec;
  wire         o_avs_waitrequest, o_res_valid, i_res_ready, o_tare_req, o_app_reset, o_unit_override, o_unit_custom;
  int          failures = 0, tests_run = 0, cyc = 0, t_prev = 0, gap = 0, tare_cnt = 0, app_cnt = 0;
  integer      seed = 32'h6c68;
  always #2.5 i_sys_clk = ~i_sys_clk;
  wrs_send_ctrl #(.REP_CYCLES(REP), .TARE_CYCLES(TARE)) i_wrs_send_ctrl (.*);
  wrs_host_sink i_wrs_host_sink (.i_clk(i_sys_clk), .i_stall(stall), .i_slow(slow), .o_ready(i_res_ready));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want)
    begin
      failures++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
    i_avs_address   <= a;
    i_avs_writedata <= d;
    i_avs_write     <= we;
    i_avs_read      <= !we;
    do
      @(posedge i_sys_clk);
    while (o_avs_waitrequest !== 1'h0);
    q = o_avs_readdata;
    i_avs_write <= '0;
    i_avs_read  <= '0;
    @(posedge i_sys_clk);
  endtask
  task automatic cmd(input logic [15:0] d);
    bus(1'h1, 5'h00, 32'(d));
  endtask
  task automatic rdg(input logic [3:0] f, input logic [23:0] v);
    {i_wgt_valid, i_wgt_stable, i_wgt_over, i_wgt_under} <= f;
    i_wgt_value <= v;
  endtask
  task automatic move(input logic [23:0] v);
    rdg(4'h8, v);
    repeat (8) @(posedge i_sys_clk);
    rdg(4'hc, v);
  endtask
  task automatic note(input logic [2:0] k, input logic [23:0] v);
    exp_q.push_back(32'({k, v}));
  endtask
  task automatic drain(input int c);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 300)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    check(32'(exp_q.size()), 32'h0);
    exp_q.delete();
    repeat (c) @(posedge i_sys_clk);
  endtask
  // result watcher: while strict is set, any result with no note pending is unexpected
  always @(posedge i_sys_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      failures++;
      $display("wrong value at %0t: run did not finish", $time);
      summarize();
    end
    tare_cnt += int'(o_tare_req);
    app_cnt  += int'(o_app_reset);
    if (o_res_valid === 1'h1 && i_res_ready === 1'h1)
    begin
      gap    = cyc - t_prev;
      t_prev = cyc;
      if (exp_q.size() != 0 || strict)
        check(32'({o_res_kind, o_res_kind < 3'h2 ? o_res_value : 24'h0}), exp_q.size() ? exp_q.pop_front() : '1);
    end
  end
  initial
  begin
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= '1;
    repeat (3) @(posedge i_sys_clk);
    bus(1'h0, 5'h08, 32'h0);
    check(q, 32'h4);
    bus(1'h0, 5'h1c, 32'h0);
    check(q, 32'h0);
    slow <= '1;
    for (int i = 0; i < 5; i++)
    begin
      w = 24'($unsigned($random(seed)) % 32'hc350 + 32'h3e8);
      rdg(FL[i], w);
      note(3'(i), i < 2 ? w : 24'h0);
      cmd(16'h1);
      drain(0);
    end
    bus(1'h1, 5'h08, 32'hc);
    rdg(4'h8, w);
    note(3'h1, w);
    i_print_key <= '1;
    @(posedge i_sys_clk);
    i_print_key <= '0;
    drain(2);
    bus(1'h1, 5'h08, 32'h4);
    $display("single send test done");
    slow <= '0;
    rdg(4'hc, w);
    repeat (3) note(3'h0, w);
    cmd(16'h2);
    drain(0);
    check(32'(gap >= REP - 1 && gap <= REP + 1), 32'h1);
    strict <= '0;
    cmd(16'h1);
    repeat (6) @(posedge i_sys_clk);
    strict <= '1;
    repeat (3 * REP) @(posedge i_sys_clk);
    $display("continuous test done");
    w = w + 24'h64;
    rdg(4'hc, w);
    note(3'h0, w);
    cmd(16'h4);
    drain(2);
    note(3'h0, w + 24'ha);
    move(w + 24'ha);
    drain(2);
    w = w + 24'hf;
    move(w);
    repeat (20) @(posedge i_sys_clk);
    bus(1'h1, 5'h04, 32'hc8);
    note(3'h0, w);
    cmd(16'h15);
    drain(2);
    w = w + 24'h12c;
    note(3'h1, w);
    note(3'h0, w);
    move(w);
    drain(2);
    bus(1'h1, 5'h04, 32'h0);
    cmd(16'h15);
    bus(1'h0, 5'h0c, 32'h0);
    check(q & 32'h7, 32'h0);
    note(3'h0, w);
    cmd(16'h5);
    drain(2);
    bus(1'h0, 5'h0c, 32'h0);
    check(q & 32'h47, 32'h45);
    bus(1'h1, 5'h04, 32'hfffff0);
    note(3'h5, 24'h0);
    cmd(16'h15);
    drain(2);
    bus(1'h1, 5'h04, 32'hc8);
    bus(1'h1, 5'h08, 32'h0);
    note(3'h5, 24'h0);
    cmd(16'h15);
    drain(2);
    bus(1'h1, 5'h08, 32'h4);
    bus(1'h1, 5'h04, 32'h0);
    cmd(16'h15);
    $display("change modes test done");
    cmd(16'h6);
    repeat (3) @(posedge i_sys_clk);
    check(32'(tare_cnt), 32'h1);
    rdg(4'h8, w);
    cmd(16'h6);
    note(3'h2, 24'h0);
    cmd(16'h1);
    note(3'h5, 24'h0);
    drain(2);
    check(32'(tare_cnt), 32'h1);
    rdg(4'ha, w);
    note(3'h5, 24'h0);
    cmd(16'h6);
    drain(2);
    rdg(4'hc, w);
    i_power_fail <= '1;
    @(posedge i_sys_clk);
    i_power_fail <= '0;
    cmd(16'h1);
    bus(1'h0, 5'h0c, 32'h0);
    check(q & 32'h100, 32'h100);
    cmd(16'h6);
    note(3'h0, w);
    cmd(16'h1);
    drain(2);
    note(3'h6, 24'h0);
    i_tare_key <= '1;
    @(posedge i_sys_clk);
    i_tare_key <= '0;
    drain(2);
    $display("tare test done");
    i_app_active <= '1;
    cmd(16'h3017);
    repeat (2) @(posedge i_sys_clk);
    check(32'({o_unit_override, o_unit_code}), 32'h13);
    check(32'(app_cnt), 32'h1);
    i_app_active <= '0;
    cmd(16'h7);
    repeat (2) @(posedge i_sys_clk);
    check(32'({o_unit_override, o_unit_custom}), 32'h0);
    bus(1'h1, 5'h04, 32'h1f4);
    cmd(16'h357);
    repeat (2) @(posedge i_sys_clk);
    check(32'({o_unit_custom, o_unit_dec, o_unit_div}), 32'ha0001f4);
    cmd(16'h217);
    repeat (2) @(posedge i_sys_clk);
    check(32'(o_unit_dec), 32'h7);
    bus(1'h1, 5'h04, 32'h32);
    note(3'h5, 24'h0);
    cmd(16'h217);
    drain(2);
    $display("unit test done");
    summarize();
  end
endmodule // tb_wrs_send_ctrl
bind wrs_send_ctrl wrs_props i_wrs_props (.*);
